// *** hdl/ssc_defines.svh ***
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_CLK_NS 100
`define SSC_CLK_MHZ 10
`define SSC_ADDR_FZC 4'h0
`define SSC_ADDR_AS 4'h1
`define SSC_ADDR_TZC 4'h2
`define SSC_ADDR_GAIN 4'h3
`define SSC_ADDR_SEQ 4'h4
`define SSC_ADDR_SHORT 4'h5
`define SSC_ADDR_KICK 4'h6
`define SSC_ADDR_JUMP 4'h7
`define SSC_ADDR_GFS 4'ha
`define SSC_ADDR_MATCH 4'hb
`define SSC_ADDR_TOGGLE 4'hc
`define SSC_ADDR_OVL 4'he
`define SSC_OP_CANCEL 4'h0
`define SSC_OP_FOCUS_ON 4'h7
`define SSC_OP_FINE 3'h2
`define SSC_OP_ONE 3'h4
`define SSC_OP_TEN 3'h5
`define SSC_OP_TWO_N 3'h6
`define SSC_OP_MOVE 3'h7
`define SSC_SRV_FOCUS_CANCEL 8'h02
`define SSC_SRV_JUMP_CANCEL 8'h25
`define SSC_FINE_STEP 16'h0008
`define SSC_TEN_STEP 16'h000a
`define SSC_MIRROR_MIN 16'h0010
`define SSC_OVL_LEN 7'h40
`define SSC_MAX_SHORT_US 2900
`define SSC_MAX_LONG_US 180000
`define SSC_SLED_FINE_US 2900
`define SSC_SLED_TWO_N_US 1450
`define SSC_BLIND_NS 22000
`define SSC_BRAKE_NS 45000
`define SSC_FKICK_NS 90000
`endif

// *** hdl/ssc_pkg.sv ***
package ssc_pkg;
  typedef enum logic {SSC_IDLE, SSC_RUN} ssc_state_t;
endpackage : ssc_pkg

// *** hdl/ssc_command_sense.sv ***
`timescale 1ns/1ns
`include "ssc_defines.svh"
module ssc_command_sense
  import ssc_pkg::*;
#(
  parameter int unsigned MAX_SHORT_CYC = `SSC_MAX_SHORT_US * `SSC_CLK_MHZ,
  parameter int unsigned MAX_LONG_CYC = `SSC_MAX_LONG_US * `SSC_CLK_MHZ,
  parameter int unsigned SLED_FINE_CYC = `SSC_SLED_FINE_US * `SSC_CLK_MHZ,
  parameter int unsigned SLED_TWO_N_CYC = `SSC_SLED_TWO_N_US * `SSC_CLK_MHZ
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_latch_n_in,
  input wire logic track_count_pulse_in,
  input wire logic mirror_signal_in,
  input wire logic efm_in,
  input wire logic chan_clk_tick_in,
  input wire logic seq_sense_enable_in,
  input wire logic focus_good_in,
  input wire logic frame_sync_good_in,
  input wire logic auto_gain_done_in,
  input wire logic average_busy_n_in,
  input wire logic avg_measure_in,
  input wire logic sled_stop_in,
  input wire logic tracking_gain_adjust_in,
  input wire logic focus_gain_adjust_in,
  input wire logic focus_zero_cross_in,
  input wire logic anti_shock_in,
  input wire logic track_zero_cross_in,
  output logic status_sense_out,
  output logic status_sense_oe_out,
  output logic seq_busy_n_out,
  output logic count_match_out,
  output logic count_toggle_out,
  output logic efm_overlength_n_out,
  output logic [7:0] servo_cmd_out,
  output logic servo_cmd_valid_out,
  output logic jump_reverse_out,
  output logic [11:0] blind_overflow_cyc_out,
  output logic [12:0] brake_cyc_out,
  output logic [18:0] sled_kick_cyc_out,
  output logic [13:0] focus_kick_cyc_out
);
  localparam logic [11:0] BLIND_CYC = 12'((`SSC_BLIND_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS);
  localparam logic [12:0] BRAKE_CYC = 13'((`SSC_BRAKE_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS);
  localparam logic [13:0] FKICK_CYC = 14'((`SSC_FKICK_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS);

  // pins: ser clk, ser data, latch, track pulse, mirror, efm
  logic [5:0] sync1_reg, sync2_reg, dly_reg;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= 6'h28; // idle pin levels, so no false edge after reset
      sync2_reg <= 6'h28;
      dly_reg <= 6'h28;
    end
    else
    begin
      sync1_reg <= {ser_clk_in, ser_data_in, ser_latch_n_in, track_count_pulse_in, mirror_signal_in, efm_in};
      sync2_reg <= sync1_reg;
      dly_reg <= sync2_reg;
    end
  end
  logic sclk_rise, latch_rise, tcp_rise, mirror_signal_rise, efm_edge;
  assign sclk_rise = sync2_reg[5] & ~dly_reg[5];
  assign latch_rise = sync2_reg[3] & ~dly_reg[3];
  assign tcp_rise = sync2_reg[2] & ~dly_reg[2];
  assign mirror_signal_rise = sync2_reg[1] & ~dly_reg[1];
  assign efm_edge = sync2_reg[0] ^ dly_reg[0];

  // serial command capture and register writes
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [3:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic [11:0] seq_cmd_reg, seq_cmd_next;
  logic [3:0] short_reg, short_next;
  logic [7:0] kick_reg, kick_next;
  logic [15:0] jump_reg, jump_next;
  logic write_seq, load_jump;
  always_comb
  begin
    bit_cnt_next = bit_cnt_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    seq_cmd_next = seq_cmd_reg;
    short_next = short_reg;
    kick_next = kick_reg;
    jump_next = jump_reg;
    write_seq = 1'b0;
    load_jump = 1'b0;
    if (!sync2_reg[3])
      bit_cnt_next = 5'h0;
    else if (sclk_rise)
    begin
      if (bit_cnt_reg < 5'h4)
      begin
        addr_next = {addr_reg[2:0], sync2_reg[4]};
        data_next = 16'h0; // a short frame must not commit old data
      end
      else
        data_next = {data_reg[14:0], sync2_reg[4]};
      if (bit_cnt_reg != 5'h1f)
        bit_cnt_next = bit_cnt_reg + 5'h1;
    end
    if (latch_rise)
    begin
      case (addr_reg)
        `SSC_ADDR_SEQ:
        begin
          seq_cmd_next = data_reg[11:0];
          write_seq = 1'b1;
        end
        `SSC_ADDR_SHORT: short_next = data_reg[3:0];
        `SSC_ADDR_KICK: kick_next = data_reg[7:0];
        `SSC_ADDR_JUMP:
        begin
          jump_next = data_reg;
          load_jump = 1'b1;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_cnt_reg <= 5'h0;
      addr_reg <= 4'h0;
      data_reg <= 16'h0;
      seq_cmd_reg <= 12'h0;
      short_reg <= 4'h0;
      kick_reg <= 8'h0;
      jump_reg <= 16'h0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      seq_cmd_reg <= seq_cmd_next;
      short_reg <= short_next;
      kick_reg <= kick_next;
      jump_reg <= jump_next;
    end
  end

  // sequencer
  ssc_state_t state_reg, state_next;
  logic [3:0] run_op_reg, run_op_next;
  logic [15:0] seq_cnt_reg, seq_cnt_next;
  logic [24:0] max_left_reg, max_left_next;
  logic max_en_reg, max_en_next;
  logic [7:0] srv_reg, srv_next;
  logic srv_vld_reg, srv_vld_next;
  logic [3:0] new_op;
  logic fine_run, tog_flip, seq_ev, seq_end, op_ok;
  logic [15:0] target;
  assign new_op = seq_cmd_next[11:8];
  assign fine_run = (state_reg == SSC_RUN) && (run_op_reg[3:1] == `SSC_OP_FINE);
  always_comb
  begin
    state_next = state_reg;
    run_op_next = run_op_reg;
    seq_cnt_next = seq_cnt_reg;
    max_left_next = max_left_reg;
    max_en_next = max_en_reg;
    srv_next = srv_reg;
    srv_vld_next = 1'b0;
    seq_ev = 1'b0;
    target = jump_reg;
    op_ok = new_op[3] | (new_op[3:1] == `SSC_OP_FINE) | (new_op == `SSC_OP_FOCUS_ON);
    case (run_op_reg[3:1])
      `SSC_OP_ONE:
      begin
        seq_ev = tcp_rise;
        target = 16'h1;
      end
      `SSC_OP_TEN:
      begin
        seq_ev = tcp_rise;
        target = `SSC_TEN_STEP;
      end
      `SSC_OP_TWO_N, `SSC_OP_MOVE: seq_ev = (jump_reg < `SSC_MIRROR_MIN) ? tog_flip : mirror_signal_rise;
      `SSC_OP_FINE: seq_ev = tog_flip;
      default: seq_ev = 1'b0;
    endcase
    if (run_op_reg == `SSC_OP_FOCUS_ON)
      seq_end = focus_good_in;
    else
      seq_end = seq_ev && (seq_cnt_reg + 16'h1 >= target);
    if (max_en_reg && max_left_reg == 25'h1)
      seq_end = 1'b1;
    if (state_reg == SSC_RUN)
    begin
      if (seq_ev)
        seq_cnt_next = seq_cnt_reg + 16'h1;
      if (max_left_reg != 25'h0)
        max_left_next = max_left_reg - 25'h1;
      if (seq_end)
        state_next = SSC_IDLE;
    end
    if (write_seq)
    begin
      if (new_op == `SSC_OP_CANCEL)
      begin
        if (state_reg == SSC_RUN)
        begin
          srv_vld_next = 1'b1;
          if (run_op_reg == `SSC_OP_FOCUS_ON)
            srv_next = `SSC_SRV_FOCUS_CANCEL;
          else
            srv_next = `SSC_SRV_JUMP_CANCEL;
        end
        state_next = SSC_IDLE;
      end
      else if (op_ok)
      begin
        state_next = SSC_RUN;
        run_op_next = new_op;
        seq_cnt_next = 16'h0;
        max_en_next = seq_cmd_next[7:4] != 4'h0;
        max_left_next = 25'(seq_cmd_next[7:4] * (seq_cmd_next[3] ? MAX_LONG_CYC : MAX_SHORT_CYC));
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= SSC_IDLE;
      run_op_reg <= 4'h0;
      seq_cnt_reg <= 16'h0;
      max_left_reg <= 25'h0;
      max_en_reg <= 1'b0;
      srv_reg <= 8'h0;
      srv_vld_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      run_op_reg <= run_op_next;
      seq_cnt_reg <= seq_cnt_next;
      max_left_reg <= max_left_next;
      max_en_reg <= max_en_next;
      srv_reg <= srv_next;
      srv_vld_reg <= srv_vld_next;
    end
  end

  // track counting for match and toggle
  logic [15:0] tc_cnt_reg, tc_cnt_next, tc_goal;
  logic match_reg, match_next, toggle_reg, toggle_next;
  always_comb
  begin
    tc_cnt_next = tc_cnt_reg;
    match_next = match_reg;
    toggle_next = toggle_reg;
    tc_goal = fine_run ? `SSC_FINE_STEP : jump_reg;
    if (load_jump)
    begin
      tc_cnt_next = 16'h0;
      match_next = 1'b1;
      toggle_next = 1'b1;
    end
    else if (tcp_rise)
    begin
      if (tc_cnt_reg + 16'h1 == tc_goal)
      begin
        tc_cnt_next = 16'h0;
        match_next = 1'b0;
        toggle_next = ~toggle_reg;
      end
      else
        tc_cnt_next = tc_cnt_reg + 16'h1;
    end
    if (write_seq && new_op[3:1] == `SSC_OP_FINE)
      tc_cnt_next = 16'h0; // a stale count would delay the first flip
    tog_flip = !load_jump && (toggle_next != toggle_reg);
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tc_cnt_reg <= 16'h0;
      match_reg <= 1'b0;
      toggle_reg <= 1'b0;
    end
    else
    begin
      tc_cnt_reg <= tc_cnt_next;
      match_reg <= match_next;
      toggle_reg <= toggle_next;
    end
  end

  // efm run length watch, counted in channel clock ticks
  logic [6:0] run_reg, run_next;
  logic ovl_n_reg, ovl_n_next;
  always_comb
  begin
    run_next = run_reg;
    ovl_n_next = ovl_n_reg;
    if (efm_edge)
    begin
      run_next = 7'h0;
      ovl_n_next = 1'b1;
    end
    else if (chan_clk_tick_in && run_reg != `SSC_OVL_LEN)
    begin
      run_next = run_reg + 7'h1;
      ovl_n_next = (run_reg + 7'h1) != `SSC_OVL_LEN;
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      run_reg <= 7'h0;
      ovl_n_reg <= 1'b1;
    end
    else
    begin
      run_reg <= run_next;
      ovl_n_reg <= ovl_n_next;
    end
  end

  // sense selection and timer figures; one cycle behind their sources
  logic sense_next, oe_next, gain_sel;
  logic [11:0] blind_next;
  logic [12:0] brake_next;
  logic [18:0] sled_next;
  logic [13:0] fkick_next;
  always_comb
  begin
    sense_next = 1'b0;
    oe_next = seq_sense_enable_in;
    gain_sel = tracking_gain_adjust_in | focus_gain_adjust_in;
    case (addr_reg)
      `SSC_ADDR_FZC: sense_next = focus_zero_cross_in;
      `SSC_ADDR_AS: sense_next = anti_shock_in;
      `SSC_ADDR_TZC: sense_next = track_zero_cross_in;
      `SSC_ADDR_GAIN: sense_next = gain_sel ? auto_gain_done_in
                                   : (avg_measure_in ? average_busy_n_in : sled_stop_in);
      `SSC_ADDR_SEQ: sense_next = state_reg != SSC_RUN;
      `SSC_ADDR_SHORT: sense_next = focus_good_in;
      `SSC_ADDR_GFS:
      begin
        sense_next = frame_sync_good_in;
        oe_next = 1'b1;
      end
      `SSC_ADDR_MATCH:
      begin
        sense_next = match_reg;
        oe_next = 1'b1;
      end
      `SSC_ADDR_TOGGLE:
      begin
        sense_next = toggle_reg;
        oe_next = 1'b1;
      end
      `SSC_ADDR_OVL:
      begin
        sense_next = ovl_n_reg;
        oe_next = 1'b1;
      end
      default: sense_next = 1'b0;
    endcase
    blind_next = 12'(short_reg * BLIND_CYC);
    brake_next = 13'(short_reg * BRAKE_CYC);
    fkick_next = 14'(kick_reg[3:0] * FKICK_CYC);
    if (run_op_reg[3:1] == `SSC_OP_FINE)
      sled_next = 19'(kick_reg[7:4] * SLED_FINE_CYC);
    else if (run_op_reg[3:1] == `SSC_OP_TWO_N)
      sled_next = 19'(kick_reg[7:4] * SLED_TWO_N_CYC);
    else
      sled_next = 19'h0;
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status_sense_out <= 1'b0;
      status_sense_oe_out <= 1'b0;
      blind_overflow_cyc_out <= 12'h0;
      brake_cyc_out <= 13'h0;
      sled_kick_cyc_out <= 19'h0;
      focus_kick_cyc_out <= 14'h0;
    end
    else
    begin
      status_sense_out <= sense_next;
      status_sense_oe_out <= oe_next;
      blind_overflow_cyc_out <= blind_next;
      brake_cyc_out <= brake_next;
      sled_kick_cyc_out <= sled_next;
      focus_kick_cyc_out <= fkick_next;
    end
  end

  assign seq_busy_n_out = state_reg != SSC_RUN;
  assign count_match_out = match_reg;
  assign count_toggle_out = toggle_reg;
  assign efm_overlength_n_out = ovl_n_reg;
  assign servo_cmd_out = srv_reg;
  assign servo_cmd_valid_out = srv_vld_reg;
  assign jump_reverse_out = run_op_reg[0];

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_cancel_focus;
    write_seq && new_op == `SSC_OP_CANCEL && state_reg == SSC_RUN && run_op_reg == `SSC_OP_FOCUS_ON;
  endsequence
  sequence s_cancel_jump;
    write_seq && new_op == `SSC_OP_CANCEL && state_reg == SSC_RUN && run_op_reg[3];
  endsequence
  sequence s_sense_disabled;
    !seq_sense_enable_in && !(addr_reg inside {`SSC_ADDR_GFS, `SSC_ADDR_MATCH, `SSC_ADDR_TOGGLE, `SSC_ADDR_OVL});
  endsequence
  a_sense_float_off: assert property (s_sense_disabled |=> !status_sense_oe_out)
    else $error("sense driven while disabled");
  a_sense_gfs_drive: assert property (addr_reg == `SSC_ADDR_GFS |=> status_sense_oe_out && status_sense_out == $past(frame_sync_good_in))
    else $error("frame sync not on sense");
  a_busy_tracks_run: assert property (write_seq && op_ok && new_op != `SSC_OP_CANCEL |=> !seq_busy_n_out)
    else $error("busy not low on start");
  a_cancel_focus_cmd: assert property (s_cancel_focus |=> servo_cmd_valid_out && servo_cmd_out == 8'h02 && seq_busy_n_out)
    else $error("focus cancel command wrong");
  a_cancel_jump_cmd: assert property (s_cancel_jump |=> servo_cmd_valid_out && servo_cmd_out == 8'h25 && seq_busy_n_out)
    else $error("jump cancel command wrong");
  a_load_sets_match: assert property (load_jump |=> count_match_out && count_toggle_out && tc_cnt_reg == 16'h0)
    else $error("count load did not set match");
  a_fine_eight_step: assert property (fine_run |-> tc_cnt_reg < 16'h8)
    else $error("fine search count passed eight");
  a_toggle_on_reach: assert property (!load_jump && tcp_rise && tc_cnt_reg + 16'h1 == tc_goal
                                      |=> count_toggle_out != $past(count_toggle_out) && !count_match_out)
    else $error("toggle missed reach");
  a_ovl_low_64: assert property (!efm_edge && chan_clk_tick_in && run_reg == 7'h3f |=> !efm_overlength_n_out)
    else $error("overlength not flagged at 64");
  a_sense_addr_switch: assert property (addr_reg == `SSC_ADDR_SHORT && seq_sense_enable_in
                                        |=> status_sense_out == $past(focus_good_in))
    else $error("focus good not on sense");
endmodule : ssc_command_sense

// *** sim/ssc_host_model.sv ***
`timescale 1ns/1ns
module ssc_host_model (
  input wire logic clk_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_latch_n_out
);
  initial
  begin
    ser_clk_out = 1'b1;
    ser_data_out = 1'b0;
    ser_latch_n_out = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // each phase held 4 ref clocks, above the 3 the sync needs
  task automatic bit_out(input logic b);
    ser_clk_out = 1'b0;
    ser_data_out = b;
    cyc(4);
    ser_clk_out = 1'b1;
    cyc(4);
  endtask : bit_out
  // bits shift while latch is high; the sense source follows the address alone
  task automatic open(input logic [3:0] a);
    for (int i = 3; i >= 0; i--)
      bit_out(a[i]);
  endtask : open
  // released data line shows the inverse, never a stale level
  // latch low pulse restarts the bit count, its rise commits the frame
  task automatic close;
    ser_data_out = ~ser_data_out;
    ser_latch_n_out = 1'b0;
    cyc(4);
    ser_latch_n_out = 1'b1;
    cyc(8);
  endtask : close
  // msb first, so the count goes high nibble first, 16 bits max
  task automatic send(input logic [3:0] a, input logic [15:0] d, input int n);
    open(a);
    for (int i = n - 1; i >= 0; i--)
      bit_out(d[i]);
    close();
  endtask : send
endmodule : ssc_host_model

// *** sim/tb_servo_sequencer_command_sense.sv ***
`timescale 1ns/1ns
module tb_servo_sequencer_command_sense;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tcp = 1'b0, mir = 1'b0, efm = 1'b0, tick = 1'b0, en = 1'b0;
  logic fg = 1'b0, fsg = 1'b0, agd = 1'b0, abn = 1'b1, avm = 1'b0, sst = 1'b0;
  logic tga = 1'b0, fga = 1'b0, fzc = 1'b0, ash = 1'b0, tzc = 1'b0;
  logic sclk, sdat, slat;
  logic sns, oe, busy_n, match, tog, ovl_n, vld, rev;
  logic [7:0] cmd;
  logic [11:0] blind;
  logic [12:0] brake;
  logic [18:0] sled;
  logic [13:0] fkick;
  int bad_count = 0;
  int tests_run = 0;
  int vcount = 0;
  logic [7:0] vcmd = 8'h00;
  logic [3:0] ops [10] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  always #50 clk = ~clk;
  // the valid strobe stands one cycle, so it is caught here
  always @(posedge clk)
    if (vld === 1'b1)
    begin
      vcount <= vcount + 1;
      vcmd <= cmd;
    end
  ssc_host_model i_ssc_host_model (.clk_in(clk), .ser_clk_out(sclk), .ser_data_out(sdat), .ser_latch_n_out(slat));
  ssc_command_sense #(.MAX_SHORT_CYC(10), .MAX_LONG_CYC(40), .SLED_FINE_CYC(10), .SLED_TWO_N_CYC(5))
  i_ssc_command_sense (
    .ref_clk_in(clk), .nrst_in(nrst), .ser_clk_in(sclk), .ser_data_in(sdat), .ser_latch_n_in(slat),
    .track_count_pulse_in(tcp), .mirror_signal_in(mir), .efm_in(efm), .chan_clk_tick_in(tick),
    .seq_sense_enable_in(en), .focus_good_in(fg), .frame_sync_good_in(fsg), .auto_gain_done_in(agd),
    .average_busy_n_in(abn), .avg_measure_in(avm), .sled_stop_in(sst), .tracking_gain_adjust_in(tga),
    .focus_gain_adjust_in(fga), .focus_zero_cross_in(fzc), .anti_shock_in(ash), .track_zero_cross_in(tzc),
    .status_sense_out(sns), .status_sense_oe_out(oe), .seq_busy_n_out(busy_n), .count_match_out(match),
    .count_toggle_out(tog), .efm_overlength_n_out(ovl_n), .servo_cmd_out(cmd), .servo_cmd_valid_out(vld),
    .jump_reverse_out(rev), .blind_overflow_cyc_out(blind), .brake_cyc_out(brake),
    .sled_kick_cyc_out(sled), .focus_kick_cyc_out(fkick)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
    i_ssc_host_model.send(a, d, n);
  endtask : wr
  task automatic seq(input logic [3:0] op, input logic [3:0] mt, input logic lng);
    wr(4'h4, {4'h0, op, mt, lng, 3'h0}, 12);
  endtask : seq
  // pulses are slow enough for the input synchronisers
  task automatic pls(input int n, input logic m);
    repeat (n)
    begin
      if (m)
        mir = 1'b1;
      else
        tcp = 1'b1;
      cyc(4);
      mir = 1'b0;
      tcp = 1'b0;
      cyc(4);
    end
  endtask : pls
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    cyc(12);
    nrst = 1'b1;
    cyc(4);
    chk({oe, busy_n, match, tog, ovl_n, vld}, 6'b010010);
    wr(4'h0, 16'h0000, 0);
    chk(oe, 1'b0);
    wr(4'ha, 16'h0000, 0);
    fsg = 1'b1;
    cyc(3);
    chk({oe, sns}, 2'b11);
    fsg = 1'b0;
    en = 1'b1;
    fzc = 1'b1;
    wr(4'h0, 16'h0000, 0);
    chk({oe, sns}, 2'b11);
    ash = 1'b1;
    wr(4'h1, 16'h0000, 0);
    chk(sns, 1'b1);
    tzc = 1'b1;
    wr(4'h2, 16'h0000, 0);
    chk(sns, 1'b1);
    i_ssc_host_model.open(4'h5);
    cyc(3);
    chk({slat, sns}, 2'b10);
    fg = 1'b1;
    cyc(3);
    chk(sns, 1'b1);
    i_ssc_host_model.close();
    wr(4'h6, 16'h0000, 0);
    chk({oe, sns}, 2'b10);
    wr(4'h3, 16'h0000, 0);
    sst = 1'b1;
    cyc(3);
    chk(sns, 1'b1);
    avm = 1'b1;
    abn = 1'b0;
    cyc(3);
    chk(sns, 1'b0);
    tga = 1'b1;
    agd = 1'b1;
    cyc(3);
    chk(sns, 1'b1);
    {tga, avm, abn, agd, fg} = 5'b00100;
    wr(4'h7, 16'h0003, 16);
    chk({match, tog}, 2'b11);
    pls(2, 1'b0);
    chk(match, 1'b1);
    pls(1, 1'b0);
    chk({match, tog}, 2'b00);
    pls(3, 1'b0);
    chk(tog, 1'b1);
    seq(4'h9, 4'h0, 1'b0);
    chk({sns, busy_n, rev}, 3'b001);
    pls(1, 1'b0);
    chk(busy_n, 1'b1);
    seq(4'ha, 4'h0, 1'b0);
    pls(9, 1'b0);
    chk(busy_n, 1'b0);
    pls(1, 1'b0);
    chk({sns, busy_n}, 2'b11);
    wr(4'h7, 16'h0014, 16);
    seq(4'h4, 4'h0, 1'b0);
    wr(4'h6, 16'h0031, 8);
    cyc(2);
    chk({sled, fkick}, {19'd30, 14'd900});
    pls(7, 1'b0);
    chk({tog, busy_n}, 2'b10);
    pls(1, 1'b0);
    chk({tog, busy_n}, 2'b00);
    pls(151, 1'b0);
    chk({tog, busy_n}, 2'b00);
    pls(1, 1'b0);
    chk({tog, busy_n}, 2'b11);
    wr(4'h7, 16'h0002, 16);
    seq(4'hc, 4'h0, 1'b0);
    chk(sled, 19'd15);
    pls(2, 1'b0);
    chk(busy_n, 1'b0);
    pls(2, 1'b0);
    chk(busy_n, 1'b1);
    wr(4'h7, 16'h0010, 16);
    seq(4'he, 4'h0, 1'b0);
    pls(3, 1'b0);
    chk(busy_n, 1'b0);
    pls(15, 1'b1);
    chk(busy_n, 1'b0);
    pls(1, 1'b1);
    chk(busy_n, 1'b1);
    wr(4'h7, 16'h0064, 16);
    foreach (ops[i])
    begin
      seq(ops[i], 4'h0, 1'b0);
      chk({busy_n, rev}, {1'b0, ops[i][0]});
      vcount = 0;
      seq(4'h0, 4'h0, 1'b0);
      chk({vcount[3:0], vcmd, busy_n}, {4'h1, 8'h25, 1'b1});
    end
    seq(4'h7, 4'h0, 1'b0);
    vcount = 0;
    seq(4'h0, 4'h0, 1'b0);
    chk({vcount[3:0], vcmd, busy_n}, {4'h1, 8'h02, 1'b1});
    seq(4'h0, 4'h0, 1'b0);
    chk(vcount, 1);
    seq(4'h7, 4'h0, 1'b0);
    fg = 1'b1;
    cyc(4);
    chk(busy_n, 1'b1);
    seq(4'hc, 4'h1, 1'b0);
    cyc(3);
    chk(busy_n, 1'b0);
    cyc(10);
    chk(busy_n, 1'b1);
    seq(4'hc, 4'h1, 1'b1);
    cyc(25);
    chk(busy_n, 1'b0);
    cyc(20);
    chk(busy_n, 1'b1);
    wr(4'h5, 16'h0001, 4);
    cyc(2);
    chk({blind, brake}, {12'd220, 13'd450});
    wr(4'h5, 16'h000f, 4);
    cyc(2);
    chk({blind, brake}, {12'd3300, 13'd6750});
    en = 1'b0;
    wr(4'he, 16'h0000, 0);
    repeat (60)
    begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
    chk({oe, sns, ovl_n}, 3'b111);
    repeat (6)
    begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
    chk({oe, sns, ovl_n}, 3'b100);
    efm = 1'b1;
    cyc(6);
    chk(ovl_n, 1'b1);
    report_and_stop();
  end
endmodule : tb_servo_sequencer_command_sense
